// *** logic/pwd_top.sv ***
// prescaled watchdog timer with an axi4-lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module pwd_top #(
  parameter int MC_CLKS = pwd_pkg::OSC_PER_MC,
  parameter int WD_W    = pwd_pkg::WD_BITS
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire pwd_pkg::pwd_axi_req_t s_axi_req,
  output var  pwd_pkg::pwd_axi_rsp_t s_axi_rsp,
  input  wire logic                  processor_sleep_bit,
  output var  logic                  processor_clk_en,
  output var  logic                  system_reset_req
);
  import pwd_pkg::*;

  localparam logic [MC_BITS-1:0] MC_LAST = MC_BITS'(MC_CLKS - 1);

  // whole state of the block
  typedef struct packed {
    logic                watchdog_run_enable;
    logic                watchdog_restart_bit;
    logic                run_in_idle_bit;
    logic [PS_W-1:0]     prescale_sel;
    logic [MC_BITS-1:0]  mc_cnt;
    logic [PRE_BITS-1:0] pre_cnt;
    logic [WD_W-1:0]     wd_cnt;
    logic                rst_req;
    logic                clk_en;
    logic                aw_have;
    logic                w_have;
    logic [11:0]         awaddr;
    logic [31:0]         wdata;
    logic                wstrb0;
    logic                rd_ctrl;
    pwd_axi_rsp_t        rsp;
  } pwd_state_t;

  pwd_state_t s_r;
  pwd_state_t s_nxt;

  // prescale select to terminal count (factor minus one)
  function automatic logic [PRE_BITS-1:0] pre_last(input logic [PS_W-1:0] ps);
    unique case (ps)
      3'h0:    pre_last = 8'h01;
      3'h2:    pre_last = 8'h03;
      3'h1:    pre_last = 8'h07;
      3'h3:    pre_last = 8'h0f;
      3'h4:    pre_last = 8'h1f;
      3'h5:    pre_last = 8'h3f;
      3'h6:    pre_last = 8'h7f;
      default: pre_last = 8'hff;
    endcase
  endfunction : pre_last

  // control register image with reserved bits at zero
  function automatic logic [31:0] ctrl_word(input pwd_state_t s);
    ctrl_word = 32'h0;
    ctrl_word[BIT_RUN]     = s.watchdog_run_enable;
    ctrl_word[BIT_RESTART] = s.watchdog_restart_bit;
    ctrl_word[BIT_IDLE]    = s.run_in_idle_bit;
    ctrl_word[PS_LSB+:PS_W] = s.prescale_sel;
  endfunction : ctrl_word

  logic mc_tick;
  logic run;
  logic pre_tick;
  logic wr_go;

  assign mc_tick  = (s_r.mc_cnt == MC_LAST);
  assign run      = s_r.watchdog_run_enable
                    && (!processor_sleep_bit || s_r.run_in_idle_bit);
  assign pre_tick = mc_tick && run && (s_r.pre_cnt == pre_last(s_r.prescale_sel));
  assign wr_go    = s_r.aw_have && s_r.w_have && !s_r.rsp.bvalid;

  // next state: counters, restart, bus
  always_comb begin
    s_nxt = s_r;
    // machine cycle divider, one tick per 12 clocks
    s_nxt.mc_cnt = mc_tick ? '0 : s_r.mc_cnt + 1'b1;
    // prescaler and main counter
    if (mc_tick && run) begin
      s_nxt.pre_cnt = pre_tick ? '0 : s_r.pre_cnt + 1'b1;
    end
    if (pre_tick) begin
      s_nxt.wd_cnt = s_r.wd_cnt + 1'b1;
      if (&s_r.wd_cnt) begin
        s_nxt.rst_req = 1'b1;
      end
    end
    // restart acts at the next machine cycle boundary
    if (s_r.watchdog_restart_bit && mc_tick) begin
      s_nxt.wd_cnt               = '0;
      s_nxt.pre_cnt              = '0;
      s_nxt.watchdog_restart_bit = 1'b0;
    end
    // processor clock gate follows sleep
    s_nxt.clk_en = !processor_sleep_bit;
    // write address and data capture
    if (s_axi_req.awvalid && s_r.rsp.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr  = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && s_r.rsp.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata  = s_axi_req.wdata;
      s_nxt.wstrb0 = s_axi_req.wstrb[0];
    end
    // response release
    if (s_r.rsp.bvalid && s_axi_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    // register write; a restart write wins over the auto clear
    if (wr_go) begin
      s_nxt.aw_have   = 1'b0;
      s_nxt.w_have    = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = RESP_OKAY;
      if (s_r.awaddr == ADDR_CTRL) begin
        if (s_r.wstrb0) begin
          s_nxt.watchdog_run_enable = s_r.wdata[BIT_RUN];
          s_nxt.run_in_idle_bit     = s_r.wdata[BIT_IDLE];
          s_nxt.prescale_sel        = s_r.wdata[PS_LSB+:PS_W];
          if (s_r.wdata[BIT_RESTART]) begin
            s_nxt.watchdog_restart_bit = 1'b1;
          end
        end
      end else if (s_r.awaddr != ADDR_STAT) begin
        s_nxt.rsp.bresp = RESP_SLVERR;
      end
    end
    // read channel
    if (s_r.rsp.rvalid && s_axi_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    if (s_axi_req.arvalid && s_r.rsp.arready) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rresp  = RESP_OKAY;
      s_nxt.rd_ctrl    = (s_axi_req.araddr == ADDR_CTRL);
      if (s_axi_req.araddr == ADDR_CTRL) begin
        s_nxt.rsp.rdata = ctrl_word(s_r);
      end else if (s_axi_req.araddr == ADDR_STAT) begin
        // status image: counter low, prescaler at 29:22, rest zero
        s_nxt.rsp.rdata              = 32'h0;
        s_nxt.rsp.rdata[WD_W-1:0]    = s_r.wd_cnt;
        s_nxt.rsp.rdata[29:22]       = s_r.pre_cnt;
      end else begin
        s_nxt.rsp.rdata = 32'h0;
        s_nxt.rsp.rresp = RESP_SLVERR;
      end
    end
    // ready terms follow the channel state
    s_nxt.rsp.awready = !s_nxt.aw_have && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready  = !s_nxt.w_have && !s_nxt.rsp.bvalid;
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r                      <= '0;
      s_r.watchdog_run_enable  <= RST_RUN;
      s_r.run_in_idle_bit      <= RST_IDLE;
      s_r.prescale_sel         <= RST_PS;
      s_r.clk_en               <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign s_axi_rsp        = s_r.rsp;
  assign processor_clk_en = s_r.clk_en;
  assign system_reset_req = s_r.rst_req;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mc_period: assert property (
    mc_tick |=> (s_r.mc_cnt == '0) ##1 (s_r.mc_cnt == 4'h1)
  ) else $error("machine cycle divider not 12 clocks");

  a_pre_factor: assert property (
    (mc_tick && run && s_r.prescale_sel == 3'h2 && s_r.pre_cnt == 8'h03
     && !s_r.watchdog_restart_bit) |=> (s_r.pre_cnt == '0)
  ) else $error("prescale factor 4 not honoured");

  a_halt_disabled: assert property (
    (!s_r.watchdog_run_enable && !s_r.watchdog_restart_bit && !wr_go)
      |=> $stable(s_r.wd_cnt) && $stable(s_r.pre_cnt)
  ) else $error("counter moved while disabled");

  a_timeout_reset: assert property (
    (pre_tick && &s_r.wd_cnt && !s_r.watchdog_restart_bit)
      |=> system_reset_req && (s_r.wd_cnt == '0)
  ) else $error("time-out gave no reset request");

  a_restart_clear: assert property (
    (s_r.watchdog_restart_bit && mc_tick && !wr_go)
      |=> (s_r.wd_cnt == '0) && (s_r.pre_cnt == '0) && !s_r.watchdog_restart_bit
  ) else $error("restart did not clear counters");

  a_idle_halt: assert property (
    (processor_sleep_bit && !s_r.run_in_idle_bit && !s_r.watchdog_restart_bit && !wr_go)
      |=> $stable(s_r.wd_cnt)
  ) else $error("watchdog ran in idle");

  a_reset_state: assert property (
    disable iff (1'b0)
    !aresetn |=> !s_r.watchdog_run_enable && (s_r.wd_cnt == '0) && (s_r.pre_cnt == '0)
  ) else $error("reset left watchdog active");

  a_cpu_gate: assert property (
    ##1 (processor_clk_en == !$past(processor_sleep_bit))
  ) else $error("processor clock gate wrong");

  a_reserved_zero: assert property (
    (s_r.rsp.rvalid && s_r.rd_ctrl) |-> (s_r.rsp.rdata[4:3] == 2'h0)
  ) else $error("reserved control bits not zero");

  // main counter steps by one on each prescaler wrap
  a_wd_step: assert property (
    (pre_tick && !s_r.watchdog_restart_bit) |=> (s_r.wd_cnt == $past(s_r.wd_cnt) + 1'b1)
  ) else $error("main counter did not step on prescaler wrap");

  // prescaler returns to zero on its terminal count
  a_pre_wrap: assert property (
    pre_tick |=> (s_r.pre_cnt == '0)
  ) else $error("prescaler did not wrap at terminal count");

  // a control write loads the run-enable bit
  a_ctrl_enable: assert property (
    (wr_go && s_r.awaddr == ADDR_CTRL && s_r.wstrb0)
      |=> (s_r.watchdog_run_enable == $past(s_r.wdata[BIT_RUN]))
  ) else $error("run-enable not loaded by control write");

  // reset request stays until chip reset
  a_req_sticky: assert property (
    system_reset_req |=> system_reset_req
  ) else $error("reset request dropped without chip reset");

  // run-in-idle keeps the prescaler moving while asleep
  a_idle_run: assert property (
    (processor_sleep_bit && s_r.run_in_idle_bit && s_r.watchdog_run_enable && mc_tick
     && !s_r.watchdog_restart_bit && !wr_go) |=> (s_r.pre_cnt != $past(s_r.pre_cnt))
  ) else $error("watchdog halted in idle despite run-in-idle");

  // write response holds until taken
  a_bresp_hold: assert property (
    (s_r.rsp.bvalid && !s_axi_req.bready) |=> s_r.rsp.bvalid && $stable(s_r.rsp.bresp)
  ) else $error("write response dropped before bready");

  // read data holds until taken
  a_rdata_hold: assert property (
    (s_r.rsp.rvalid && !s_axi_req.rready) |=> s_r.rsp.rvalid && $stable(s_r.rsp.rdata)
  ) else $error("read data dropped before rready");

  // no new write accepted while a response is pending
  a_write_refused: assert property (
    s_r.rsp.bvalid |-> !s_r.rsp.awready && !s_r.rsp.wready
  ) else $error("write accepted while response pending");

  // no new read accepted while read data is pending
  a_read_refused: assert property (
    s_r.rsp.rvalid |-> !s_r.rsp.arready
  ) else $error("read accepted while data pending");

  // unmapped read answers with an error and zero data
  a_read_unmapped: assert property (
    (s_axi_req.arvalid && s_r.rsp.arready && s_axi_req.araddr != ADDR_CTRL
     && s_axi_req.araddr != ADDR_STAT)
      |=> (s_r.rsp.rresp == RESP_SLVERR) && (s_r.rsp.rdata == 32'h0)
  ) else $error("unmapped read not refused");

  // covers of the main scenarios
  c_write_ctrl: cover property (wr_go && s_r.awaddr == ADDR_CTRL);
  c_restart:    cover property (s_r.watchdog_restart_bit && mc_tick);
  c_timeout:    cover property ($rose(system_reset_req));
  c_idle_run:   cover property (processor_sleep_bit && run && pre_tick);

endmodule : pwd_top

`default_nettype wire

// *** logic/pwd_pkg.sv ***
// package of constants and types for the prescaled watchdog
package pwd_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CTRL    = 10'h08f;
  localparam logic [9:0]  IDX_STAT    = 10'h090;
  localparam logic [11:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STAT   = {IDX_STAT, 2'b00};
  // control field positions
  localparam int          BIT_RUN     = 7;
  localparam int          BIT_RESTART = 6;
  localparam int          BIT_IDLE    = 5;
  localparam int          PS_LSB      = 0;
  localparam int          PS_W        = 3;
  // reset values
  localparam logic        RST_RUN     = 1'b0;
  localparam logic        RST_IDLE    = 1'b0;
  localparam logic [2:0]  RST_PS      = 3'h0;
  // timing counts
  localparam int          OSC_PER_MC  = 12;
  localparam int          WD_BITS     = 14;
  localparam int          PRE_BITS    = 8;
  localparam int          MC_BITS     = 4;
  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // requests from the bus master
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } pwd_axi_req_t;

  // answers to the bus master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pwd_axi_rsp_t;
endpackage : pwd_pkg

// *** dv/tb_top.sv ***
// self-checking bench for the prescaled watchdog timer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import pwd_pkg::*;
  localparam int WDW = 2;
  logic         aclk;
  logic         aresetn;
  pwd_axi_req_t req;
  pwd_axi_rsp_t rsp;
  logic         sleep;
  logic         clk_en;
  logic         rst_req;
  int           n_errors;
  int           tests_run;
  int           cycles;
  int           seed;
  int           ctrl_m;
  int           fac [8] = '{2, 8, 4, 16, 32, 64, 128, 256};
  logic [31:0]  rd;
  logic [31:0]  d;
  logic [1:0]   rr;

  pwd_top #(.MC_CLKS(OSC_PER_MC), .WD_W(WDW)) i_pwd_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
    .processor_sleep_bit(sleep), .processor_clk_en(clk_en), .system_reset_req(rst_req));

  // free-running 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // write: both halves offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= dv;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    while (aw || w || rsp.bvalid !== 1'b1) begin
      @(posedge aclk);
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    rr = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rdw(input logic [11:0] a);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    @(posedge aclk);
    while (rsp.arready !== 1'b1) @(posedge aclk);
    req.arvalid <= 1'b0;
    @(posedge aclk);
    while (rsp.rvalid !== 1'b1) @(posedge aclk);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask : rdw

  // mid-run chip reset; bus is idle here
  task automatic rst_pulse();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, rst_req}, 32'h0);
  endtask : rst_pulse

  // enable with restart, then time the reset request against the model
  task automatic tmo(input logic [7:0] c, input int f);
    int n;
    int t;
    t = (1 << WDW) * f * OSC_PER_MC;
    wr(ADDR_CTRL, {24'h0, c}, 4'hf);
    n = 0;
    while (rst_req !== 1'b1 && n < t + 40) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, rst_req}, 32'h1);
    chk(32'(n >= t - 12 && n <= t + 24), 32'h1);
  endtask : tmo

  // main sequence
  initial begin
    aresetn = 1'b0;
    req = '0;
    sleep = 1'b0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    seed = 32'ha401;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdw(ADDR_CTRL);
    chk(rd, 32'h0);
    chk({31'h0, clk_en}, 32'h1);
    rdw(12'hffc);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    // random control values, enable kept off
    for (int i = 0; i < 6; i++) begin
      d = $random(seed) & 32'h7f;
      wr(ADDR_CTRL, d, 4'hf);
      chk({30'h0, rr}, {30'h0, RESP_OKAY});
      ctrl_m = d & 32'h27;
      rdw(ADDR_CTRL);
      chk(rd & 32'hbf, ctrl_m);
    end
    wr(ADDR_CTRL, 32'hff, 4'h0);
    rdw(ADDR_CTRL);
    chk(rd & 32'hbf, ctrl_m);
    wr(ADDR_CTRL, 32'h40, 4'hf);
    repeat (13) @(posedge aclk);
    rdw(ADDR_CTRL);
    chk(rd, 32'h0);
    // every prescale code times out at its own period
    for (int c = 0; c < 8; c++) begin
      rst_pulse();
      tmo(8'hc0 | 8'(c), fac[c]);
    end
    // disabled counter never fires
    rst_pulse();
    wr(ADDR_CTRL, 32'h47, 4'hf);
    repeat (136) @(posedge aclk);
    chk({31'h0, rst_req}, 32'h0);
    // idle halts unless run-in-idle is set
    rst_pulse();
    sleep <= 1'b1;
    wr(ADDR_CTRL, 32'hc0, 4'hf);
    repeat (136) @(posedge aclk);
    chk({31'h0, rst_req}, 32'h0);
    chk({31'h0, clk_en}, 32'h0);
    tmo(8'he0, 2);
    sleep <= 1'b0;
    // regular restarts keep the request away
    rst_pulse();
    wr(ADDR_CTRL, 32'hc0, 4'hf);
    repeat (6) begin
      repeat (40) @(posedge aclk);
      wr(ADDR_CTRL, 32'hc0, 4'hf);
    end
    chk({31'h0, rst_req}, 32'h0);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
